// ---- include/slpcg_pkg.sv ----
// Shared types and constants for the sleep-mode clock gating block.
// Assumes a single 40 MHz system clock and an active-low external reset pin.
package slpcg_pkg;

  // ----------------------------------------
  // Counts and reset values
  // ----------------------------------------
  localparam int unsigned RST_SYNC_STAGES = 2;
  localparam int unsigned PORT_WIDTH = 8;
  localparam logic [7:0] PIN_RESET_VALUE = 8'h00;

  // ----------------------------------------
  // Modes and states
  // ----------------------------------------
  typedef enum logic [2:0] {
    SLPCG_IDLE,
    SLPCG_ADC_NOISE,
    SLPCG_POWER_DOWN,
    SLPCG_POWER_SAVE,
    SLPCG_STANDBY,
    SLPCG_EXT_STANDBY
  } slpcg_mode_type;

  typedef enum logic {
    SLPCG_RUN,
    SLPCG_SLEEP
  } slpcg_state_type;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic core;
    logic sram;
    logic io;
    logic irq;
    logic async_tmr;
    logic adc;
    logic osc;
  } slpcg_clk_type;

  typedef struct packed {
    logic [PORT_WIDTH-1:0] first_port_pins;
    logic [PORT_WIDTH-1:0] second_port_pins;
    logic [PORT_WIDTH-1:0] third_port_pins;
    logic [PORT_WIDTH-1:0] fourth_port_pins;
  } slpcg_port_type;

  localparam slpcg_clk_type CLK_ALL_ON = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam slpcg_clk_type CLK_ALL_OFF = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam slpcg_port_type PORT_RESET_VALUE = '{PIN_RESET_VALUE, PIN_RESET_VALUE,
                                                  PIN_RESET_VALUE, PIN_RESET_VALUE};

endpackage

// ---- rtl/slpcg_rst_sync.sv ----
// Reset synchronizer: asserts at once, releases after a few clock edges.
// Assumes arst may arrive with no clock running.
`timescale 1ns/10ps
module slpcg_rst_sync #(
  parameter int unsigned STAGES = slpcg_pkg::RST_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic arst,
  output logic rst_out
);

  logic [STAGES-1:0] shift_q;

  // Release is synchronous so no flop sees reset end mid-setup window
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      shift_q <= '1;
    end else begin
      shift_q <= {shift_q[STAGES-2:0], 1'b0};
    end
  end

  assign rst_out = shift_q[STAGES-1];

endmodule

// ---- rtl/slpcg_top.sv ----
// Sleep-mode clock gating and reset gating for a small microcontroller.
// Assumes the core raises sleep_req for one cycle when it executes sleep,
// and that the clock enables drive glitch-free gates outside this block.
`timescale 1ns/10ps
module slpcg_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_reset_n,
  input wire logic sleep_en,
  input wire slpcg_pkg::slpcg_mode_type sleep_mode,
  input wire logic sleep_req,
  input wire logic irq_sync,
  input wire logic irq_async,
  input wire logic irq_timer,
  input wire slpcg_pkg::slpcg_port_type port_dout,
  input wire slpcg_pkg::slpcg_port_type port_doe,
  output slpcg_pkg::slpcg_clk_type clk_en_q,
  output logic sleeping_q,
  output logic dev_reset_q,
  output slpcg_pkg::slpcg_port_type pin_out_q,
  output slpcg_pkg::slpcg_port_type pin_oe_q
);

  // ----------------------------------------
  // Gating table
  // ----------------------------------------
  function automatic slpcg_pkg::slpcg_clk_type gate_for(input slpcg_pkg::slpcg_mode_type m);
    slpcg_pkg::slpcg_clk_type g;
    g = slpcg_pkg::CLK_ALL_OFF;
    case (m)
      slpcg_pkg::SLPCG_IDLE: begin
        g = slpcg_pkg::CLK_ALL_ON;
        g.core = 1'b0;
      end
      slpcg_pkg::SLPCG_ADC_NOISE: begin
        g.irq = 1'b1;
        g.async_tmr = 1'b1;
        g.adc = 1'b1;
        g.osc = 1'b1;
      end
      slpcg_pkg::SLPCG_POWER_DOWN: begin
        g = slpcg_pkg::CLK_ALL_OFF;
      end
      slpcg_pkg::SLPCG_POWER_SAVE: begin
        g.async_tmr = 1'b1;
      end
      slpcg_pkg::SLPCG_STANDBY: begin
        g.osc = 1'b1;
      end
      slpcg_pkg::SLPCG_EXT_STANDBY: begin
        g.osc = 1'b1;
        g.async_tmr = 1'b1;
      end
      default: begin
        g = slpcg_pkg::CLK_ALL_ON;
      end
    endcase
    return g;
  endfunction

  // ----------------------------------------
  // Reset combination
  // ----------------------------------------
  // Pin reset needs no clock; a short glitch on the pin may also reset, which is harmless
  wire logic any_rst;
  wire logic dev_rst;

  assign any_rst = rst | ~ext_reset_n;

  slpcg_rst_sync #(
    .STAGES(slpcg_pkg::RST_SYNC_STAGES)
  ) slpcg_rst_sync_i (
    .clk(clk),
    .arst(any_rst),
    .rst_out(dev_rst)
  );

  // ----------------------------------------
  // Sleep state
  // ----------------------------------------
  slpcg_pkg::slpcg_state_type state_q;
  slpcg_pkg::slpcg_state_type state_d;
  slpcg_pkg::slpcg_mode_type mode_q;
  slpcg_pkg::slpcg_mode_type mode_d;
  slpcg_pkg::slpcg_clk_type clk_en_d;

  wire logic go_sleep;
  wire logic wake;
  wire slpcg_pkg::slpcg_clk_type mode_gate;

  assign mode_gate = gate_for(mode_q);
  // A clocked interrupt only wakes where its domain still has a clock
  assign wake = irq_async | (irq_sync & mode_gate.irq)
              | (irq_timer & mode_gate.async_tmr);
  // A clock-free or clocked interrupt in the same cycle keeps the core running; irq_timer does not
  assign go_sleep = sleep_req & sleep_en & ~irq_async & ~irq_sync;

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    case (state_q)
      slpcg_pkg::SLPCG_RUN: begin
        if (go_sleep) begin
          state_d = slpcg_pkg::SLPCG_SLEEP;
          mode_d = sleep_mode;
        end
      end
      slpcg_pkg::SLPCG_SLEEP: begin
        if (wake) begin
          state_d = slpcg_pkg::SLPCG_RUN;
        end
      end
      default: begin
        state_d = slpcg_pkg::SLPCG_RUN;
      end
    endcase
  end

  assign clk_en_d = (state_d == slpcg_pkg::SLPCG_SLEEP) ? gate_for(mode_d)
                                                       : slpcg_pkg::CLK_ALL_ON;

  // Reset brings every clock back so the core can run its reset sequence
  always_ff @(posedge clk or posedge dev_rst) begin
    if (dev_rst) begin
      state_q <= slpcg_pkg::SLPCG_RUN;
      mode_q <= slpcg_pkg::SLPCG_IDLE;
      clk_en_q <= slpcg_pkg::CLK_ALL_ON;
      sleeping_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      clk_en_q <= clk_en_d;
      sleeping_q <= (state_d == slpcg_pkg::SLPCG_SLEEP);
    end
  end

  // ----------------------------------------
  // Device reset and port pins
  // ----------------------------------------
  always_ff @(posedge clk or posedge any_rst) begin
    if (any_rst) begin
      dev_reset_q <= 1'b1;
      pin_out_q <= slpcg_pkg::PORT_RESET_VALUE;
      pin_oe_q <= slpcg_pkg::PORT_RESET_VALUE;
    end else begin
      dev_reset_q <= dev_rst;
      pin_out_q <= port_dout;
      // Pins stay released until the synchronized reset has ended
      pin_oe_q <= dev_rst ? slpcg_pkg::PORT_RESET_VALUE : port_doe;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  wire logic in_sleep;
  assign in_sleep = (state_q == slpcg_pkg::SLPCG_SLEEP);

  property p_sleep_entry;
    @(posedge clk) disable iff (dev_rst)
    (state_q == slpcg_pkg::SLPCG_RUN) && sleep_req && sleep_en && !irq_async && !irq_sync
      |=> in_sleep && sleeping_q && (mode_q == $past(sleep_mode));
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_no_sleep_disabled;
    @(posedge clk) disable iff (dev_rst)
    (state_q == slpcg_pkg::SLPCG_RUN) && !sleep_en |=> clk_en_q.core;
  endproperty
  a_no_sleep_disabled: assert property (p_no_sleep_disabled) else $error("core gated");

  property p_idle;
    @(posedge clk) disable iff (dev_rst)
    in_sleep && (mode_q == slpcg_pkg::SLPCG_IDLE)
      |-> !clk_en_q.core && clk_en_q.sram && clk_en_q.io && clk_en_q.irq;
  endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong");

  property p_power_down;
    @(posedge clk) disable iff (dev_rst)
    in_sleep && (mode_q == slpcg_pkg::SLPCG_POWER_DOWN) |-> clk_en_q == slpcg_pkg::CLK_ALL_OFF;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down gating wrong");

  property p_power_save;
    @(posedge clk) disable iff (dev_rst)
    in_sleep && (mode_q == slpcg_pkg::SLPCG_POWER_SAVE)
      |-> clk_en_q.async_tmr && !clk_en_q.core && !clk_en_q.osc;
  endproperty
  a_power_save: assert property (p_power_save) else $error("power-save gating wrong");

  property p_adc_noise;
    @(posedge clk) disable iff (dev_rst)
    in_sleep && (mode_q == slpcg_pkg::SLPCG_ADC_NOISE)
      |-> !clk_en_q.core && !clk_en_q.io && clk_en_q.async_tmr && clk_en_q.adc;
  endproperty
  a_adc_noise: assert property (p_adc_noise) else $error("adc mode gating wrong");

  property p_standby;
    @(posedge clk) disable iff (dev_rst)
    in_sleep && (mode_q == slpcg_pkg::SLPCG_STANDBY)
      |-> clk_en_q.osc && !clk_en_q.core && !clk_en_q.async_tmr && !clk_en_q.io;
  endproperty
  a_standby: assert property (p_standby) else $error("standby gating wrong");

  property p_ext_standby;
    @(posedge clk) disable iff (dev_rst)
    in_sleep && (mode_q == slpcg_pkg::SLPCG_EXT_STANDBY)
      |-> clk_en_q.osc && clk_en_q.async_tmr && !clk_en_q.core && !clk_en_q.sram;
  endproperty
  a_ext_standby: assert property (p_ext_standby) else $error("ext standby gating wrong");

  property p_pin_reset;
    @(posedge clk) disable iff (rst)
    !ext_reset_n |-> dev_reset_q && (pin_oe_q == slpcg_pkg::PORT_RESET_VALUE);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not applied");

  property p_reset_release;
    @(posedge clk) disable iff (rst)
    !ext_reset_n ##1 ext_reset_n [*4] |-> !dev_reset_q;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset stuck");

  property p_tristate;
    @(posedge clk) disable iff (rst)
    dev_reset_q |-> pin_oe_q == slpcg_pkg::PORT_RESET_VALUE;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pins driven in reset");

  property p_wake;
    @(posedge clk) disable iff (dev_rst)
    in_sleep && irq_async |=> clk_en_q == slpcg_pkg::CLK_ALL_ON && !sleeping_q;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");

  property p_stay_asleep;
    @(posedge clk) disable iff (dev_rst)
    in_sleep && !irq_async && !(irq_sync && clk_en_q.irq)
      && !(irq_timer && clk_en_q.async_tmr) |=> in_sleep && $stable(mode_q);
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) else $error("spurious wake");

  c_idle_wake: cover property (@(posedge clk) disable iff (dev_rst)
    in_sleep && (mode_q == slpcg_pkg::SLPCG_IDLE) ##1 !in_sleep);
  c_power_down: cover property (@(posedge clk) disable iff (dev_rst)
    in_sleep && (mode_q == slpcg_pkg::SLPCG_POWER_DOWN) && irq_async);
  c_timer_wake: cover property (@(posedge clk) disable iff (dev_rst)
    in_sleep && (mode_q == slpcg_pkg::SLPCG_POWER_SAVE) && irq_timer);
  c_pin_reset: cover property (@(posedge clk) disable iff (rst)
    !ext_reset_n ##1 ext_reset_n [*4]);

endmodule

// ---- verification/sleep_mode_clock_gating_tb.sv ----
// Self-checking bench for slpcg_top with a behavioural core beside it.
// Assumes registered outputs settle 2 ns after each rising edge.
`timescale 1ns/10ps
module sleep_mode_clock_gating_tb;
  logic clk = 1'b0;
  logic clk_run = 1'b1;
  logic rst = 1'b1;
  logic irq_sync = 1'b0;
  logic irq_async = 1'b0;
  logic irq_timer = 1'b0;
  slpcg_pkg::slpcg_port_type port_dout = '0;
  slpcg_pkg::slpcg_port_type port_doe = '0;
  logic sleep_en, sleep_req, ext_reset_n, sleeping_q, dev_reset_q;
  slpcg_pkg::slpcg_mode_type sleep_mode;
  slpcg_pkg::slpcg_clk_type clk_en_q;
  slpcg_pkg::slpcg_port_type pin_out_q, pin_oe_q;
  slpcg_pkg::slpcg_mode_type m;
  int unsigned mismatches = 0;
  int unsigned checked = 0;
  int s;

  // Gated so a clock-free reset can be shown
  always #12.5 if (clk_run) clk = ~clk;

  slpcg_core_model slpcg_core_model_i (.clk(clk), .sleep_en(sleep_en),
    .sleep_mode(sleep_mode), .sleep_req(sleep_req), .ext_reset_n(ext_reset_n));
  slpcg_top slpcg_top_i (.clk(clk), .rst(rst), .ext_reset_n(ext_reset_n),
    .sleep_en(sleep_en), .sleep_mode(sleep_mode), .sleep_req(sleep_req),
    .irq_sync(irq_sync), .irq_async(irq_async), .irq_timer(irq_timer),
    .port_dout(port_dout), .port_doe(port_doe), .clk_en_q(clk_en_q),
    .sleeping_q(sleeping_q), .dev_reset_q(dev_reset_q), .pin_out_q(pin_out_q),
    .pin_oe_q(pin_oe_q));

  // ----------------------------------------
  // Expectations and helpers
  // ----------------------------------------
  function automatic slpcg_pkg::slpcg_clk_type exp_clk(input slpcg_pkg::slpcg_mode_type md);
    case (md)
      slpcg_pkg::SLPCG_IDLE: return 7'h3f;
      slpcg_pkg::SLPCG_ADC_NOISE: return 7'h0f;
      slpcg_pkg::SLPCG_POWER_DOWN: return 7'h00;
      slpcg_pkg::SLPCG_POWER_SAVE: return 7'h04;
      slpcg_pkg::SLPCG_STANDBY: return 7'h01;
      slpcg_pkg::SLPCG_EXT_STANDBY: return 7'h05;
      default: return 7'h7f;
    endcase
  endfunction

  // Source 0 clock-free, 1 clocked irq, 2 async timer
  function automatic logic wakes(input int src, input slpcg_pkg::slpcg_mode_type md);
    slpcg_pkg::slpcg_clk_type e;
    e = exp_clk(md);
    return (src == 0) || (src == 1 && e.irq) || (src == 2 && e.async_tmr);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #2;
  endtask

  task automatic enter(input slpcg_pkg::slpcg_mode_type md);
    slpcg_core_model_i.sleep(md, 1'b1);
    check(32'(sleeping_q), 32'h1);
    check(32'(clk_en_q), 32'(exp_clk(md)));
  endtask

  // Level held over one sampling edge only
  task automatic raise_irq(input int src);
    irq_async = (src == 0);
    irq_sync = (src == 1);
    irq_timer = (src == 2);
    tick();
    irq_async = 1'b0;
    irq_sync = 1'b0;
    irq_timer = 1'b0;
  endtask

  task automatic wake_case(input slpcg_pkg::slpcg_mode_type md, input int src);
    enter(md);
    raise_irq(src);
    check(32'(clk_en_q), wakes(src, md) ? 32'h7f : 32'(exp_clk(md)));
    raise_irq(0);
    check(32'(clk_en_q), 32'h7f);
    check(32'(sleeping_q), 32'h0);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    void'($urandom(90736));
    repeat (3) @(posedge clk);
    #2;
    rst = 1'b0;
    repeat (2) tick();
    check(32'(dev_reset_q), 32'h1);
    tick();
    check(32'(dev_reset_q), 32'h0);
    for (int i = 0; i < 18; i++) begin
      wake_case(slpcg_pkg::slpcg_mode_type'(i / 3), i % 3);
    end
    slpcg_core_model_i.sleep(slpcg_pkg::SLPCG_IDLE, 1'b0);
    check(32'(sleeping_q), 32'h0);
    irq_async = 1'b1;
    slpcg_core_model_i.sleep(slpcg_pkg::SLPCG_IDLE, 1'b1);
    irq_async = 1'b0;
    check(32'(sleeping_q), 32'h0);
    irq_sync = 1'b1;
    slpcg_core_model_i.sleep(slpcg_pkg::SLPCG_IDLE, 1'b1);
    irq_sync = 1'b0;
    check(32'(sleeping_q), 32'h0);
    enter(slpcg_pkg::SLPCG_POWER_SAVE);
    slpcg_core_model_i.sleep(slpcg_pkg::SLPCG_IDLE, 1'b1);
    check(32'(clk_en_q), 32'h04);
    raise_irq(0);
    for (int i = 0; i < 20; i++) begin
      m = slpcg_pkg::slpcg_mode_type'($urandom_range(5));
      s = $urandom_range(2);
      port_dout = $urandom;
      port_doe = $urandom;
      tick();
      check(pin_oe_q, port_doe);
      check(pin_out_q, port_dout);
      wake_case(m, s);
    end
    // Reset in mid-sleep: pins released at once, clocks restored
    enter(slpcg_pkg::SLPCG_POWER_DOWN);
    port_doe = '1;
    rst = 1'b1;
    #1 check(pin_oe_q, 32'h0);
    check(32'(dev_reset_q), 32'h1);
    repeat (2) tick();
    rst = 1'b0;
    repeat (3) tick();
    check(32'(dev_reset_q), 32'h0);
    check(32'(clk_en_q), 32'h7f);
    check(pin_oe_q, 32'hffffffff);
    // Pin reset with the clock stopped
    enter(slpcg_pkg::SLPCG_STANDBY);
    @(negedge clk);
    clk_run = 1'b0;
    #100 slpcg_core_model_i.pin_set(1'b0);
    #1 check(32'(dev_reset_q), 32'h1);
    check(pin_oe_q, 32'h0);
    #50 clk_run = 1'b1;
    repeat (4) tick();
    slpcg_core_model_i.pin_set(1'b1);
    repeat (3) tick();
    check(32'(dev_reset_q), 32'h0);
    check(32'(sleeping_q), 32'h0);
    // One more edge so the release window of the pin reset is seen whole
    tick();
    check(32'(dev_reset_q), 32'h0);
    close_out();
  end

  initial begin
    #100000;
    mismatches++;
    close_out();
  end
endmodule

// ---- verification/slpcg_core_model.sv ----
// Behavioural processor core: sleep instruction pulse and reset pin.
// Assumes its sleep task is called just after a rising clock edge.
`timescale 1ns/10ps
module slpcg_core_model (
  input wire logic clk,
  output logic sleep_en,
  output slpcg_pkg::slpcg_mode_type sleep_mode,
  output logic sleep_req,
  output logic ext_reset_n
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    sleep_en = 1'b0;
    sleep_mode = slpcg_pkg::SLPCG_IDLE;
    sleep_req = 1'b0;
    ext_reset_n = 1'b1;
  end

  // ----------------------------------------
  // Requests
  // ----------------------------------------
  // One-cycle pulse; enable and mode stay as left, like the register would
  task automatic sleep(input slpcg_pkg::slpcg_mode_type m, input logic en);
    sleep_en = en;
    sleep_mode = m;
    sleep_req = 1'b1;
    @(posedge clk);
    #2;
    sleep_req = 1'b0;
  endtask

  // Caller times the pulse, so it also works with the clock stopped
  task automatic pin_set(input logic v);
    ext_reset_n = v;
  endtask
endmodule
